// file: core/pwm_generator.sv
// Top of the pulse width modulator: APB registers, period buffering and output sequencing.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_params.svh"

// Behaviour
// - off value n gives n+1 off ticks
// - off value zero holds output on
// - reset: off all ones, config zero
// - pre-divider divides source by value plus one
// - pre-divider zero counts every source cycle
// - config bit 1 selects slow source
// - config bit 2 makes on level low
// - disable clears counters, forces off state
// - disabled output sits at inactive level
// - period registers unaffected by enable bit
// - disabled gates counting clocks, restarts fresh
// - on value n gives n+1 on ticks
// - on zero, off nonzero holds output off
// - writes buffered, copied after four bytes
// - reads return active values, not holding
module pwm_generator (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             pwm_output
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Builds the 32-bit read word of a 16-bit period; upper bits read zero.
   function automatic logic [31:0] pwm_period_word(input logic [15:0] value);
      pwm_period_word = {16'h0000, value};
   endfunction : pwm_period_word

   // Merges the two low byte lanes of a write into a 16-bit field.
   function automatic logic [15:0] pwm_merge16(input logic [15:0] old_value,
                                               input logic [15:0] new_value,
                                               input logic [1:0]  lanes);
      pwm_merge16 = {lanes[1] ? new_value[15:8] : old_value[15:8],
                     lanes[0] ? new_value[7:0]  : old_value[7:0]};
   endfunction : pwm_merge16

   // ****************************************************************
   // Register state
   // ****************************************************************
   // The holding pair takes every write; the active pair feeds the counter
   // and is what software reads back.
   pwm_pkg::pwm_cfg_type  cfg;
   pwm_pkg::pwm_state_type state;
   logic [15:0]           on_active;
   logic [15:0]           off_active;
   logic [15:0]           on_hold;
   logic [15:0]           off_hold;
   logic [3:0]            hold_bytes;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // Only an exact word address hits a register. Any other address, a
   // misaligned one included, ends with an error and changes nothing.
   wire        apb_access  = psel & penable;
   // A transfer commits at the edge where the access phase meets ready.
   wire        apb_commit  = apb_access & pready;
   wire        answer_now  = apb_access & ~pready;
   wire        sel_on      = (paddr == `PWM_OFS_ON_PERIOD);
   wire        sel_off     = (paddr == `PWM_OFS_OFF_PERIOD);
   wire        sel_cfg     = (paddr == `PWM_OFS_CONFIG);
   wire        sel_status  = (paddr == `PWM_OFS_STATUS);
   wire        addr_hit    = sel_on | sel_off | sel_cfg | sel_status;
   wire        write_ok    = apb_commit & pwrite & addr_hit;
   wire        wr_on       = write_ok & sel_on;
   wire        wr_off      = write_ok & sel_off;
   wire        wr_cfg      = write_ok & sel_cfg & pstrb[0];
   // Lanes two and three carry no period bits and are ignored.
   wire [3:0]  wr_lanes    = {wr_off ? pstrb[1:0] : 2'b00,
                              wr_on  ? pstrb[1:0] : 2'b00};

   // Status word: pending holding bytes, phase and output level. Software
   // polls the byte flags to learn whether an update is still waiting.
   wire        status_level = pwm_output;
   wire        status_phase = (state == pwm_pkg::PWM_ST_ON);
   wire        status_spare = 1'b0;
   wire [31:0] status_word  = {25'h0000000,
                               status_level,
                               status_phase,
                               status_spare,
                               hold_bytes};

   wire [31:0] cfg_word    = {25'h0000000,
                              cfg.prediv,
                              cfg.invert,
                              cfg.clk_sel,
                              cfg.enable};

   wire [31:0] read_word   = sel_on     ? pwm_period_word(on_active)  :
                             sel_off    ? pwm_period_word(off_active) :
                             sel_cfg    ? cfg_word                    :
                             sel_status ? status_word                 :
                                          32'h00000000;

   // ****************************************************************
   // APB response
   // ****************************************************************
   // One wait state per transfer: the answer is registered so every bus
   // output comes straight from a flip-flop.
   wire        next_pready  = answer_now;
   wire        next_pslverr = answer_now & ~addr_hit;
   wire [31:0] next_prdata  = (answer_now & ~pwrite) ? read_word : 32'h00000000;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ****************************************************************
   // Configuration register
   // ****************************************************************
   // Every configuration bit sits in byte lane zero, so a write that leaves
   // that lane out is dropped whole rather than half applied.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg <= pwm_pkg::pwm_cfg_type'(`PWM_RST_CONFIG);
      end else if (ce && wr_cfg) begin
         cfg.enable  <= pwdata[`PWM_CFG_ENABLE_BIT];
         cfg.clk_sel <= pwdata[`PWM_CFG_CLK_SEL_BIT];
         cfg.invert  <= pwdata[`PWM_CFG_INVERT_BIT];
         cfg.prediv  <= pwdata[`PWM_CFG_PREDIV_MSB:`PWM_CFG_PREDIV_LSB];
      end
   end

   // ****************************************************************
   // Counting clock and down counter
   // ****************************************************************
   // The prescaler hands over one-cycle ticks, not a divided clock, so the
   // whole block stays on the system clock and nothing crosses domains.
   logic        count_tick;
   logic        count_zero;

   pwm_prescaler u_prescaler (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ce         (ce),
      .cfg        (cfg),
      .count_tick (count_tick)
   );

   wire enabled    = cfg.enable;
   // A step is one tick of the selected, pre-divided counting clock.
   wire step       = enabled & count_tick;
   wire phase_end  = step & count_zero;
   wire in_on      = (state == pwm_pkg::PWM_ST_ON);
   wire off_done   = phase_end & ~in_on;

   // ****************************************************************
   // Period buffering
   // ****************************************************************
   // Full-on and full-off follow the active values only; pending holding
   // contents never change the output until they are transferred.
   wire full_on    = (off_active == 16'h0000);
   wire full_off   = (on_active == 16'h0000) & ~full_on;
   wire hold_full  = &hold_bytes;
   // A disabled generator never ends an off count, so a complete update is
   // taken at once rather than left waiting for the next enable.
   wire transfer   = hold_full & (off_done | full_on | ~enabled);

   wire [15:0] next_on_src  = transfer ? on_hold  : on_active;
   wire [15:0] next_off_src = transfer ? off_hold : off_active;
   wire        next_full_off = (next_on_src == 16'h0000) & (next_off_src != 16'h0000);

   wire [15:0] next_on_hold    = pwm_merge16(on_hold, pwdata[15:0], pstrb[1:0]);
   wire [15:0] next_off_hold   = pwm_merge16(off_hold, pwdata[15:0], pstrb[1:0]);
   // A byte written in the same cycle as a transfer stays marked pending.
   wire [3:0]  next_hold_bytes = (transfer ? 4'h0 : hold_bytes) | wr_lanes;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         on_hold  <= `PWM_RST_ON_PERIOD;
         off_hold <= `PWM_RST_OFF_PERIOD;
      end else if (ce) begin
         if (wr_on) begin
            on_hold <= next_on_hold;
         end
         if (wr_off) begin
            off_hold <= next_off_hold;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hold_bytes <= 4'h0;
      end else if (ce) begin
         hold_bytes <= next_hold_bytes;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         on_active  <= `PWM_RST_ON_PERIOD;
         off_active <= `PWM_RST_OFF_PERIOD;
      end else if (ce && transfer) begin
         on_active  <= on_hold;
         off_active <= off_hold;
      end
   end

   // ****************************************************************
   // Phase sequencing
   // ****************************************************************
   // The counter holds n through n+1 ticks of a phase: loaded with n at the
   // phase start, stepped down to zero, and the tick that finds zero ends it.
   wire        cnt_clear = ~enabled;
   wire        cnt_load  = phase_end;
   wire        cnt_dec   = step & ~count_zero;
   // Leaving the on phase, or staying off in full off, loads the off count;
   // otherwise the next on count is loaded.
   wire [15:0] cnt_value = (in_on | next_full_off) ? next_off_src
                                                   : next_on_src;

   pwm_down_counter u_counter (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ce         (ce),
      .clear      (cnt_clear),
      .load       (cnt_load),
      .load_value (cnt_value),
      .dec        (cnt_dec),
      .count      (),
      .zero       (count_zero)
   );

   // A disabled generator parks in the off phase, so a later enable always
   // opens with a one-tick off phase counted from an empty counter.
   pwm_pkg::pwm_state_type next_state;

   always_comb begin
      next_state = state;
      if (!enabled) begin
         next_state = pwm_pkg::PWM_ST_OFF;
      end else if (phase_end) begin
         unique case (state)
            pwm_pkg::PWM_ST_ON: begin
               next_state = pwm_pkg::PWM_ST_OFF;
            end
            pwm_pkg::PWM_ST_OFF: begin
               next_state = next_full_off ? pwm_pkg::PWM_ST_OFF
                                          : pwm_pkg::PWM_ST_ON;
            end
            default: begin
               next_state = pwm_pkg::PWM_ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= pwm_pkg::PWM_ST_OFF;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Output pin
   // ****************************************************************
   // The pin follows the phase one cycle late; this keeps it glitch free
   // at the price of a single system clock of skew against the counter.
   wire on_level   = full_on | (in_on & ~full_off);
   // A disabled pin shows the inactive level of the chosen polarity.
   wire next_out   = enabled ? (on_level ^ cfg.invert)
                             : cfg.invert;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pwm_output <= 1'b0;
      end else if (ce) begin
         pwm_output <= next_out;
      end
   end

endmodule : pwm_generator

`default_nettype wire

// file: core/pwm_params.svh
// Register offsets, field positions, reset values and timing counts of the pulse width modulator.
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define PWM_ADDR_W            12
`define PWM_OFS_ON_PERIOD     12'h000
`define PWM_OFS_OFF_PERIOD    12'h004
`define PWM_OFS_CONFIG        12'h008
`define PWM_OFS_STATUS        12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
`define PWM_CFG_ENABLE_BIT    0
`define PWM_CFG_CLK_SEL_BIT   1
`define PWM_CFG_INVERT_BIT    2
`define PWM_CFG_PREDIV_LSB    3
`define PWM_CFG_PREDIV_MSB    6

// ****************************************************************
// Reset values
// ****************************************************************
`define PWM_RST_ON_PERIOD     16'h0000
`define PWM_RST_OFF_PERIOD    16'hffff
`define PWM_RST_CONFIG        7'h00

// ****************************************************************
// Timing
// ****************************************************************
`define PWM_SYS_CLK_HZ        25000000
`define PWM_SLOW_SRC_HZ       100000
`define PWM_SLOW_DIV_CYCLES   (`PWM_SYS_CLK_HZ / `PWM_SLOW_SRC_HZ)

`endif

// file: core/pwm_pkg.sv
// Types shared by the pulse width modulator modules.
package pwm_pkg;

   typedef struct packed {
      logic [3:0] prediv;
      logic       invert;
      logic       clk_sel;
      logic       enable;
   } pwm_cfg_type;

   typedef enum logic [1:0] {
      PWM_ST_ON  = 2'b01,
      PWM_ST_OFF = 2'b10
   } pwm_state_type;

endpackage : pwm_pkg

// file: core/pwm_prescaler.sv
// Counting-clock source selection and pre-divider producing one tick per counter step.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_params.svh"

module pwm_prescaler (
   input  wire logic                sys_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire pwm_pkg::pwm_cfg_type cfg,
   output logic                     count_tick
);

   localparam logic [7:0] SLOW_LAST = 8'(`PWM_SLOW_DIV_CYCLES - 1);

   logic [7:0] slow_cnt;
   logic [3:0] div_cnt;

   wire        slow_tick = (slow_cnt == SLOW_LAST);
   wire        src_tick  = cfg.clk_sel ? slow_tick : 1'b1;
   wire        div_done  = (div_cnt >= cfg.prediv);

   // ****************************************************************
   // Clock emulation: a disabled generator holds both dividers at zero,
   // which stands in for gating the counting clocks off.
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         slow_cnt   <= 8'h00;
         div_cnt    <= 4'h0;
         count_tick <= 1'b0;
      end else if (ce) begin
         if (!cfg.enable) begin
            slow_cnt   <= 8'h00;
            div_cnt    <= 4'h0;
            count_tick <= 1'b0;
         end else begin
            slow_cnt   <= slow_tick ? 8'h00 : slow_cnt + 8'h01;
            count_tick <= src_tick & div_done;
            if (src_tick) begin
               div_cnt <= div_done ? 4'h0 : div_cnt + 4'h1;
            end
         end
      end
   end

endmodule : pwm_prescaler

`default_nettype wire

// file: core/pwm_down_counter.sv
// Sixteen-bit loadable down counter that times the on and off phases.
`timescale 1ns/100ps
`default_nettype none

module pwm_down_counter (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        clear,
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   input  wire logic        dec,
   output logic [15:0]      count,
   output logic             zero
);

   assign zero = (count == 16'h0000);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
      end else if (ce) begin
         if (clear) begin
            count <= 16'h0000;
         end else if (load) begin
            count <= load_value;
         end else if (dec) begin
            count <= count - 16'h0001;
         end
      end
   end

endmodule : pwm_down_counter

`default_nettype wire

// file: tb/pwm_generator_sva.sv
// Port checker for the pulse width modulator, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module pwm_generator_sva (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pwm_output
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [6:0]  cfg;
   logic [15:0] age;
   logic [15:0] run;
   logic        last;
   wire         cfg_wr = ce && psel && penable && pready && pwrite && paddr == 12'h008 && pstrb[0];
   // Runs are only judged once the config is older than the run, so edits never shorten one.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg  <= 7'h00;
         age  <= 16'h0000;
         run  <= 16'h0000;
         last <= 1'b0;
      end else begin
         last <= pwm_output;
         run  <= (pwm_output != last) ? 16'h0001 : ((run == 16'hfff0) ? run : run + 16'h0001);
         if (cfg_wr) begin
            cfg <= pwdata[6:0];
            age <= 16'h0000;
         end else if (age != 16'hffff) begin
            age <= age + 16'h0001;
         end
      end
   end
   chk_ready_wait: assert property (
      (psel && penable && !pready) |=> pready)
      else $error("ready did not follow the wait state");
   chk_ready_pulse: assert property (
      pready |=> !pready) else $error("ready stood longer than one cycle");
   chk_ready_access: assert property (
      pready |-> psel && penable) else $error("ready outside an access phase");
   chk_err_map: assert property (
      (pready && paddr[1:0] == 2'b00) |-> pslverr == (paddr > 12'h00c))
      else $error("error flag does not match the address map");
   chk_idle_bus: assert property (
      !pready |-> (prdata == 32'h0 && !pslverr)) else $error("read bus not idle");
   chk_reset_out: assert property (
      $fell(rst) |-> !pwm_output) else $error("output not low after reset");
   chk_idle_level: assert property (
      (age > 16'h0003 && !cfg[0]) |-> pwm_output == cfg[2])
      else $error("disabled output not at inactive level");
   chk_phase_len: assert property (
      ({1'b0, age} > {1'b0, run} + 17'h00003 && cfg[0] && pwm_output != last)
      |-> run >= {12'h000, cfg[6:3]} + 16'h0001) else $error("phase shorter than one tick");
   cover property (pready && pslverr);
   cover property (cfg_wr && pwdata[0]);
   cover property (cfg[0] && pwm_output != last);
endmodule : pwm_generator_sva
bind pwm_generator pwm_generator_sva pwm_generator_sva_inst (.sys_clk(sys_clk), .rst(rst),
   .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output(pwm_output));
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the pulse width modulator.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [3:0]  pstrb   = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pwm_output;
   logic [31:0] rd;
   logic        er;
   int          err_total = 0;
   int          samples_checked = 0;
   always #20 sys_clk = ~sys_clk;
   pwm_generator pwm_generator_inst (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output(pwm_output));
   task automatic stop_test();
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Values read right after an edge are the ones that edge sampled.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n       = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         check("apb ready", 32'h1, 32'h0);
         stop_test();
      end
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      check(what, exp, rd);
   endtask : rdchk
   task automatic set_cfg(input logic [6:0] v);
      apb(1'b1, 12'h008, 32'h0, 4'h1);
      apb(1'b1, 12'h008, {25'h0, v}, 4'h1);
   endtask : set_cfg
   task automatic run_len(input logic lvl, output int len);
      int n;
      int ph;
      n   = 0;
      ph  = 0;
      len = 0;
      while (ph < 3 && n < 3000) begin
         @(posedge sys_clk);
         n++;
         if ((pwm_output === lvl) == (ph == 1)) begin
            ph++;
         end
         if (ph == 2) begin
            len++;
         end
      end
      if (n >= 3000) begin
         check("output run", 32'h1, 32'h0);
         stop_test();
      end
   endtask : run_len
   task automatic hold(input logic lvl);
      repeat (20) begin
         @(posedge sys_clk);
         check("held level", {31'h0, lvl}, {31'h0, pwm_output});
      end
   endtask : hold
   task automatic t_reset();
      check("output after reset", 32'h0, {31'h0, pwm_output});
      rdchk("on reset", 12'h000, 32'h0);
      rdchk("off reset", 12'h004, 32'hffff);
      rdchk("config reset", 12'h008, 32'h0);
      apb(1'b1, 12'h010, 32'h1, 4'hf);
      check("unmapped error", 32'h1, {31'h0, er});
   endtask : t_reset
   task automatic t_basic();
      logic [3:0] pd [3];
      int         len;
      pd = '{4'h0, 4'h1, 4'hf};
      apb(1'b1, 12'h000, 32'h1, 4'h3);
      apb(1'b1, 12'h004, 32'h2, 4'h3);
      rdchk("on period", 12'h000, 32'h1);
      rdchk("off period", 12'h004, 32'h2);
      foreach (pd[i]) begin
         set_cfg({pd[i], 3'b001});
         run_len(1'b1, len);
         check("on run", 32'((int'(pd[i]) + 1) * 2), 32'(len));
         run_len(1'b0, len);
         check("off run", 32'((int'(pd[i]) + 1) * 3), 32'(len));
      end
   endtask : t_basic
   task automatic t_invert();
      int len;
      set_cfg(7'h05);
      run_len(1'b0, len);
      check("inverted on run", 32'h2, 32'(len));
      run_len(1'b1, len);
      check("inverted off run", 32'h3, 32'(len));
      apb(1'b1, 12'h008, 32'h4, 4'h1);
      repeat (4) @(posedge sys_clk);
      check("disabled inverted", 32'h1, {31'h0, pwm_output});
      apb(1'b1, 12'h008, 32'h0, 4'h1);
      repeat (4) @(posedge sys_clk);
      check("disabled plain", 32'h0, {31'h0, pwm_output});
      rdchk("on kept", 12'h000, 32'h1);
      rdchk("off kept", 12'h004, 32'h2);
      rdchk("status idle", 12'h00c, 32'h0);
   endtask : t_invert
   task automatic t_holding();
      int len;
      set_cfg(7'h01);
      apb(1'b1, 12'h000, 32'h5, 4'h1);
      rdchk("on not pending", 12'h000, 32'h1);
      apb(1'b1, 12'h000, 32'h0, 4'h2);
      apb(1'b1, 12'h004, 32'h3, 4'h3);
      run_len(1'b1, len);
      run_len(1'b1, len);
      check("updated on run", 32'h6, 32'(len));
      run_len(1'b0, len);
      check("updated off run", 32'h4, 32'(len));
      rdchk("on active", 12'h000, 32'h5);
      apb(1'b1, 12'h000, 32'h1, 4'h1);
      apb(1'b0, 12'h00c, 32'h0, 4'h0);
      check("pending bytes", 32'h1, {28'h0, rd[3:0]});
      repeat (30) @(posedge sys_clk);
      run_len(1'b1, len);
      check("partial write unused", 32'h6, 32'(len));
   endtask : t_holding
   task automatic t_full();
      int len;
      apb(1'b1, 12'h000, 32'h3, 4'h3);
      apb(1'b1, 12'h004, 32'h0, 4'h3);
      repeat (30) @(posedge sys_clk);
      hold(1'b1);
      apb(1'b1, 12'h000, 32'h0, 4'h3);
      apb(1'b1, 12'h004, 32'h4, 4'h3);
      repeat (5) @(posedge sys_clk);
      hold(1'b0);
      apb(1'b1, 12'h008, 32'h0, 4'h1);
      apb(1'b1, 12'h000, 32'h1, 4'h3);
      apb(1'b1, 12'h004, 32'h1, 4'h3);
      apb(1'b1, 12'h008, 32'h3, 4'h1);
      run_len(1'b1, len);
      check("slow on run", 32'h1f4, 32'(len));
      run_len(1'b0, len);
      check("slow off run", 32'h1f4, 32'(len));
   endtask : t_full
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_basic();
      t_invert();
      t_holding();
      t_full();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
